// ---- pbc_analog_model.sv ----
/*
  Behavioural model of the crystal oscillator and pll analog side: both source
  clocks as sampled levels and a lock level.
  Assumes it shares core_clk_in with the block and takes the block's enables.
*/
`timescale 1ns/100ps
module pbc_analog_model #(
  parameter int XTAL_HALF = 2,
  parameter int LOCK_DLY = 20
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // enables from the block, unlock command from the bench
  input wire logic osc_en_in,
  input wire logic pll_en_in,
  input wire logic unlock_in,
  // analog outputs
  output logic crystal_clock_out,
  output logic vco_clock_out,
  output logic lock_out
);
  int xcnt;
  int lcnt;

  ////////////////////////////////////////////////////////////////////////////
  // sources stand still while their enable is low
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      xcnt <= 0;
      lcnt <= 0;
      crystal_clock_out <= 1'b0;
      vco_clock_out <= 1'b0;
    end else begin
      if (osc_en_in) begin
        xcnt <= (xcnt == XTAL_HALF - 1) ? 0 : xcnt + 1;
        if (xcnt == XTAL_HALF - 1) crystal_clock_out <= ~crystal_clock_out;
      end
      if (pll_en_in) vco_clock_out <= ~vco_clock_out;
      lcnt <= pll_en_in ? ((lcnt == LOCK_DLY) ? lcnt : lcnt + 1) : 0;
    end
  end

  // lock reported once the loop has settled, dropped on command
  assign lock_out = (lcnt == LOCK_DLY) && !unlock_in;
endmodule

// ---- pbc_base_clock_selector.sv ----
/*
  Digital control of the clock generator: control, bandwidth and
  multiplier/range registers on classic Wishbone, power/select interlock,
  lock-change flag and interrupt, and the transition circuit instance.
  Assumes the analog oscillator, vco, lock detector and stop decode are outside.
*/
// Function
// - multiplier zero acts as multiplier one
// - zero range disables pll, forces crystal
// - switch waits three edges of each running clock
// - base clock frozen while switching
// - transition output divided by two
// - bus clock is half base clock
// - select bit set picks vco clock
// - vco select refused while pll off
// - pll off refused while vco selected
// - combined power and select change rejected
// - base clock fifty percent duty
// - interrupt driven from lock detector
// - oscillator enable gates crystal and pll
// - centre frequency is range times nominal
// - multiplier writes ignored while pll on
// - reset and stop clear select bit
// - lock toggle sets flag, raises interrupt
`timescale 1ns/100ps
module pbc_base_clock_selector import pbc_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // source clocks, sampled levels
  input wire logic crystal_clock_in,
  input wire logic vco_clock_in,
  // system and analog status
  input wire logic oscillator_enable_in,
  input wire logic stop_in,
  input wire logic lock_in,
  // analog controls
  output logic oscillator_enable_out,
  output logic pll_enable_out,
  output logic [3:0] feedback_divider_out,
  output logic [3:0] vco_range_out,
  output logic [19:0] vco_center_100hz_out,
  // clocks and interrupt
  output logic base_clock_out,
  output logic bus_clock_out,
  output logic switching_out,
  output logic vco_active_out,
  output logic lock_change_interrupt_out
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode shared by the write and read paths
  function automatic logic reg_hit(input logic [9:0] adr, input logic [7:0] idx);
    return adr == {idx, 2'b00};
  endfunction

  pbc_wb_req_s wb;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic access, wr_en, wr_ctrl, wr_bw, wr_mr, rd_ctrl;

  // bus request carrier
  assign wb = {wb_adr_in, wb_dat_in, wb_sel_in, wb_we_in, wb_cyc_in & wb_stb_in};

  // one access per request; ack falls the cycle after it rose
  assign access = wb.req & ~ack_q;
  assign wr_en = access & wb.we & wb.sel[0];
  assign wr_ctrl = wr_en & reg_hit(wb.adr, PBC_IDX_CTRL);
  assign wr_bw = wr_en & reg_hit(wb.adr, PBC_IDX_BW);
  assign wr_mr = wr_en & reg_hit(wb.adr, PBC_IDX_MR);
  assign rd_ctrl = access & ~wb.we & reg_hit(wb.adr, PBC_IDX_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // control, bandwidth and lock state
  pbc_ctrl_s ctrl_q, ctrl_d;
  pbc_mr_s mr_q, mr_d;
  logic auto_q, auto_d;
  logic lock_q, lock_d;
  logic lock_toggle, range_zero;
  logic new_on, new_vsel, combined;

  assign range_zero = (mr_q.range == PBC_NIB_ZERO);
  assign new_on = wb.dat[PBC_CTRL_ON_BIT];
  assign new_vsel = wb.dat[PBC_CTRL_VSEL_BIT];
  // a write that flips both power and selection is refused whole
  assign combined = (new_on != ctrl_q.pll_on) && (new_vsel != ctrl_q.vsel);
  // lock changes only count while automatic bandwidth is on
  assign lock_toggle = auto_q && (lock_in != lock_q);

  // next control state
  always_comb begin
    ctrl_d = ctrl_q;
    auto_d = auto_q;
    lock_d = auto_q & lock_in;
    if (wr_ctrl && !combined) begin
      if (auto_q) begin
        ctrl_d.irq_en = wb.dat[PBC_CTRL_IE_BIT];
      end
      if (new_on || !ctrl_q.vsel) begin
        ctrl_d.pll_on = new_on;
      end
      if (!new_vsel || ctrl_q.pll_on) begin
        ctrl_d.vsel = new_vsel;
      end
    end
    if (wr_bw) begin
      auto_d = wb.dat[PBC_BW_AUTO_BIT];
    end
    // reading the control register clears the flag; a toggle in the same
    // cycle still sets it
    if (rd_ctrl) begin
      ctrl_d.flag = 1'b0;
    end
    if (lock_toggle) begin
      ctrl_d.flag = 1'b1;
    end
    if (stop_in) begin
      ctrl_d.vsel = 1'b0;
    end
    if (range_zero) begin
      ctrl_d.vsel = 1'b0;
    end
  end

  // control registers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_q <= '{irq_en: 1'b0, flag: 1'b0, pll_on: 1'b1, vsel: 1'b0};
      auto_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      auto_q <= auto_d;
      lock_q <= lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiplier/range register and derived analog settings
  logic [3:0] div_q, div_d;
  logic [19:0] center_q, center_d;
  logic osc_en_q, osc_en_d, pll_en_q, pll_en_d;

  // upper nibble multiplier, lower nibble range
  always_comb begin
    mr_d = mr_q;
    if (wr_mr && !ctrl_q.pll_on) begin
      mr_d = wb.dat[7:0];
    end
    div_d = (mr_d.mul == PBC_NIB_ZERO) ? PBC_MUL_ONE : mr_d.mul;
    center_d = 20'(mr_d.range) * PBC_NOM_FREQ_100HZ;
    osc_en_d = oscillator_enable_in;
    pll_en_d = oscillator_enable_in & ctrl_q.pll_on & ~range_zero;
  end

  // programming registers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mr_q <= PBC_MR_RESET;
      div_q <= PBC_MR_RESET[7:4];
      center_q <= 20'h00000;
      osc_en_q <= 1'b0;
      pll_en_q <= 1'b0;
    end else begin
      mr_q <= mr_d;
      div_q <= div_d;
      center_q <= center_d;
      osc_en_q <= osc_en_d;
      pll_en_q <= pll_en_d;
    end
  end

  assign oscillator_enable_out = osc_en_q;
  assign pll_enable_out = pll_en_q;
  assign feedback_divider_out = div_q;
  assign vco_range_out = mr_q.range;
  assign vco_center_100hz_out = center_q;

  ////////////////////////////////////////////////////////////////////////////
  // read data and acknowledge
  always_comb begin
    ack_d = access;
    rdat_d = rdat_q;
    if (access && !wb.we) begin
      rdat_d = 32'h00000000;
      if (reg_hit(wb.adr, PBC_IDX_CTRL)) begin
        rdat_d[7:0] = {ctrl_q.irq_en & auto_q, ctrl_q.flag & auto_q, ctrl_q.pll_on,
                       ctrl_q.vsel, PBC_CTRL_UNUSED};
      end else if (reg_hit(wb.adr, PBC_IDX_BW)) begin
        rdat_d[PBC_BW_AUTO_BIT] = auto_q;
        rdat_d[PBC_BW_LOCK_BIT] = lock_q;
      end else if (reg_hit(wb.adr, PBC_IDX_MR)) begin
        rdat_d[7:0] = mr_q;
      end
    end
  end

  // bus answer registers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt from the lock detector path
  assign lock_change_interrupt_out = ctrl_q.flag & ctrl_q.irq_en & auto_q;

  ////////////////////////////////////////////////////////////////////////////
  // transition circuit, vco only requested when the range allows it
  pbc_clock_switch u_switch (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .sel_vco_in(ctrl_q.vsel & ~range_zero),
    .src_clk_in({vco_clock_in, crystal_clock_in}),
    .src_alive_in({pll_en_q, osc_en_q}),
    .base_clock_out(base_clock_out),
    .bus_clock_out(bus_clock_out),
    .switching_out(switching_out),
    .vco_active_out(vco_active_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_mul_zero_one: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (mr_q.mul == PBC_NIB_ZERO) |-> feedback_divider_out == PBC_MUL_ONE)
    else $error("zero multiplier not treated as one");

  a_range_zero_xtal: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    range_zero |=> !ctrl_q.vsel && !pll_enable_out)
    else $error("zero range left vco selectable");

  a_vsel_needs_on: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (wr_ctrl && !ctrl_q.pll_on && !ctrl_q.vsel) |=> !ctrl_q.vsel)
    else $error("vco selected while pll off");

  a_on_held_vsel: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (wr_ctrl && ctrl_q.vsel && ctrl_q.pll_on) |=> ctrl_q.pll_on)
    else $error("pll turned off while vco selected");

  a_no_combined: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (wr_ctrl && combined && !stop_in && !range_zero)
    |=> ctrl_q.pll_on == $past(ctrl_q.pll_on) && ctrl_q.vsel == $past(ctrl_q.vsel))
    else $error("combined power and select change accepted");

  a_mr_locked: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    ctrl_q.pll_on |=> mr_q == $past(mr_q))
    else $error("multiplier written while pll on");

  a_stop_clears: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    stop_in |=> !ctrl_q.vsel ##3 (!vco_active_out || switching_out))
    else $error("stop did not clear vco select");

  a_flag_irq: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (lock_toggle && ctrl_q.irq_en && !wr_ctrl && !wr_bw)
    |=> ctrl_q.flag && lock_change_interrupt_out)
    else $error("lock toggle did not raise interrupt");

  a_osc_gates: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !oscillator_enable_in |=> !oscillator_enable_out && !pll_enable_out)
    else $error("oscillator enable did not gate pll");

  a_center_freq: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $changed(mr_q) |-> vco_center_100hz_out == 20'(mr_q.range) * PBC_NOM_FREQ_100HZ)
    else $error("centre frequency wrong");

  a_ack_one: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (wb.req && !ack_q) |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single cycle");

  c_vco_select: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !ctrl_q.vsel ##1 ctrl_q.vsel);
  c_lock_irq: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $rose(lock_change_interrupt_out));
  c_combined_refused: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    wr_ctrl && combined);

endmodule

// ---- pbc_clock_switch.sv ----
/*
  Glitch-free transition circuit: switches between crystal and vco clocks,
  holds the output steady during a switch, then divides by two for the base
  clock and again for the bus clock.
  Assumes both source clocks are sampled levels synchronous to core_clk_in.
*/
`timescale 1ns/100ps
module pbc_clock_switch import pbc_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // selection request and sources, index 0 crystal, 1 vco
  input wire logic sel_vco_in,
  input wire logic [1:0] src_clk_in,
  input wire logic [1:0] src_alive_in,
  // clocks out and status
  output logic base_clock_out,
  output logic bus_clock_out,
  output logic switching_out,
  output logic vco_active_out
);

  pbc_sw_state_e state_q, state_d;
  logic [1:0] src_q;
  logic [1:0] rise;
  logic [1:0] src_done;
  logic [1:0][1:0] cnt_q, cnt_d;
  logic req_meta_q, req_sync_q;
  logic active_q, active_d, base_q, base_d, bus_q, bus_d;

  ////////////////////////////////////////////////////////////////////////////
  // per-source edge detect and edge-count completion
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_src
      assign rise[i] = src_clk_in[i] & ~src_q[i];
      // a stopped source is not waited for, or the switch would hang
      assign src_done[i] = ~src_alive_in[i] | (cnt_q[i] == PBC_SWITCH_EDGES);
    end
  endgenerate

  // switch sequencing and output dividers
  always_comb begin
    state_d = state_q;
    active_d = active_q;
    cnt_d = cnt_q;
    base_d = base_q;
    bus_d = bus_q;
    for (int k = 0; k < 2; k++) begin
      if (rise[k] && cnt_q[k] != PBC_SWITCH_EDGES) begin
        cnt_d[k] = cnt_q[k] + 2'h1;
      end
    end
    unique case (state_q)
      SW_RUN: begin
        cnt_d = '0;
        if (req_sync_q != active_q) begin
          state_d = SW_WAIT;
        end else if (rise[active_q]) begin
          base_d = ~base_q;
          if (!base_q) begin
            bus_d = ~bus_q;
          end
        end
      end
      SW_WAIT: begin
        // output held: base_d keeps base_q
        if (&src_done) begin
          active_d = req_sync_q;
          state_d = SW_RUN;
        end
      end
    endcase
  end

  // registers, request passes two stages before use
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_q <= SW_RUN;
      src_q <= 2'h0;
      cnt_q <= '0;
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      active_q <= 1'b0;
      base_q <= 1'b0;
      bus_q <= 1'b0;
    end else begin
      state_q <= state_d;
      src_q <= src_clk_in;
      cnt_q <= cnt_d;
      req_meta_q <= sel_vco_in;
      req_sync_q <= req_meta_q;
      active_q <= active_d;
      base_q <= base_d;
      bus_q <= bus_d;
    end
  end

  assign base_clock_out = base_q;
  assign bus_clock_out = bus_q;
  assign switching_out = (state_q == SW_WAIT);
  assign vco_active_out = active_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_base_stasis: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_q == SW_WAIT |=> base_clock_out == $past(base_clock_out))
    else $error("base clock moved during switch");
  a_switch_edges: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state_q == SW_WAIT && !(&src_done)) |=> state_q == SW_WAIT)
    else $error("switch ended before source edges counted");
  a_divide_two: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state_q == SW_RUN && req_sync_q == active_q && rise[active_q])
    |=> base_clock_out != $past(base_clock_out))
    else $error("base clock missed a source edge");
  a_bus_half: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $changed(bus_clock_out) |-> $rose(base_clock_out))
    else $error("bus clock not half of base clock");
  c_switch_done: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_q == SW_WAIT ##1 state_q == SW_RUN ##1 active_q);

endmodule

// ---- pbc_pkg.sv ----
/*
  Shared constants and types for the base clock selector: register indexes,
  field positions, reset values, switch timing and the bus request carrier.
  Assumes a 32-bit classic Wishbone bus whose registers occupy the low byte lane.
*/
package pbc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indexes, byte address is index times four
  localparam logic [7:0] PBC_IDX_CTRL = 8'h1C;
  localparam logic [7:0] PBC_IDX_BW = 8'h1D;
  localparam logic [7:0] PBC_IDX_MR = 8'h1E;
  localparam int unsigned PBC_ADR_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // pll_control_reg fields
  localparam int unsigned PBC_CTRL_IE_BIT = 7;
  localparam int unsigned PBC_CTRL_F_BIT = 6;
  localparam int unsigned PBC_CTRL_ON_BIT = 5;
  localparam int unsigned PBC_CTRL_VSEL_BIT = 4;
  localparam logic [3:0] PBC_CTRL_UNUSED = 4'hF;

  // bandwidth register fields
  localparam int unsigned PBC_BW_AUTO_BIT = 7;
  localparam int unsigned PBC_BW_LOCK_BIT = 6;

  // pll_multiplier_range reset value and special codes
  localparam logic [7:0] PBC_MR_RESET = 8'h66;
  localparam logic [3:0] PBC_NIB_ZERO = 4'h0;
  localparam logic [3:0] PBC_MUL_ONE = 4'h1;

  // nominal vco centre frequency, 4.9152 MHz in units of 100 Hz
  localparam logic [19:0] PBC_NOM_FREQ_100HZ = 20'h0C000;

  // source edges counted during a switch
  localparam logic [1:0] PBC_SWITCH_EDGES = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic {SW_RUN, SW_WAIT} pbc_sw_state_e;

  typedef struct packed {
    logic irq_en;
    logic flag;
    logic pll_on;
    logic vsel;
  } pbc_ctrl_s;

  typedef struct packed {
    logic [3:0] mul;
    logic [3:0] range;
  } pbc_mr_s;

  typedef struct packed {
    logic [9:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic req;
  } pbc_wb_req_s;

endpackage

// ---- pll_base_clock_selector_tb.sv ----
/*
  Self-checking bench for the base clock selector: bus reads are queued with
  their expected data and checked by a monitor; clocks are measured directly.
  Assumes the analog model supplies the source clocks and lock level.
*/
`timescale 1ns/100ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module pll_base_clock_selector_tb;
  import pbc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic ack, xclk, vclk, osc_en = 1'b1, stop = 1'b0, lock, unlock = 1'b0;
  logic osc_out, pll_out, base, bus, sw, vact, irq, prev_base, prev_sw = 1'b0;
  logic [3:0] div, rng;
  logic [19:0] ctr;
  logic [31:0] expq[$];
  logic [31:0] exp_v;
  logic [31:0] rnd = 32'hFDED;
  int num_errors = 0, n_compared = 0, sw_len = 0;

  always #10 clk = ~clk;

  pbc_base_clock_selector u_dut (.core_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .crystal_clock_in(xclk), .vco_clock_in(vclk),
    .oscillator_enable_in(osc_en), .stop_in(stop), .lock_in(lock),
    .oscillator_enable_out(osc_out), .pll_enable_out(pll_out), .feedback_divider_out(div),
    .vco_range_out(rng), .vco_center_100hz_out(ctr), .base_clock_out(base),
    .bus_clock_out(bus), .switching_out(sw), .vco_active_out(vact),
    .lock_change_interrupt_out(irq));

  pbc_analog_model u_model (.core_clk_in(clk), .sys_rst_in(rst), .osc_en_in(osc_out),
    .pll_en_in(pll_out), .unlock_in(unlock), .crystal_clock_out(xclk),
    .vco_clock_out(vclk), .lock_out(lock));

  ////////////////////////////////////////////////////////////////////////////
  // closing report
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // one classic single cycle; reads note their expected data first
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    if (!w) expq.push_back({24'h0, d});
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      $display("ERROR %0t: bus request never acknowledged", $time);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // counts source rises and base/bus edges over 64 cycles
  task automatic measure(input logic use_vco);
    int sr, bt, bu, hi;
    logic ps, pb, pu, s;
    sr = 0;
    bt = 0;
    bu = 0;
    hi = 0;
    ps = use_vco ? vclk : xclk;
    pb = base;
    pu = bus;
    repeat (64) begin
      @(posedge clk);
      s = use_vco ? vclk : xclk;
      if (s && !ps) sr++;
      if (base !== pb) bt++;
      if (bus !== pu) bu++;
      if (base) hi++;
      ps = s;
      pb = base;
      pu = bus;
    end
    `CHK((bt >= sr - 1 && bt <= sr + 1), 1'b1)
    `CHK((2 * bu >= bt - 2 && 2 * bu <= bt + 2), 1'b1)
    `CHK((hi >= 28 && hi <= 36), 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // monitor: read results against the queue, base frozen and switch length
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) begin
        num_errors++;
        $display("ERROR %0t: read data with no expectation", $time);
      end else begin
        // take the note once, the macro evaluates its arguments twice
        exp_v = expq.pop_front();
        `CHK(rdat, exp_v)
      end
    end
    if (sw === 1'b1 && prev_sw === 1'b1) `CHK(base, prev_base)
    if (sw === 1'b1) sw_len <= sw_len + 1;
    if (sw === 1'b0 && prev_sw === 1'b1) begin
      `CHK((sw_len >= 5 && sw_len <= 16), 1'b1)
      sw_len <= 0;
    end
    prev_sw <= sw;
    prev_base <= base;
  end

  // watchdog: the sequence needs a few hundred cycles
  initial begin
    wait_cyc(20000);
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] v;
    wait_cyc(4);
    rst <= 1'b0;
    wait_cyc(2);
    wb(0, PBC_IDX_CTRL, 8'h2F);
    wb(0, PBC_IDX_BW, 8'h00);
    wb(0, PBC_IDX_MR, PBC_MR_RESET);
    wb(0, 8'hFF, 8'h00);
    wb(1, PBC_IDX_MR, 8'h11);
    wb(0, PBC_IDX_MR, PBC_MR_RESET);
    wb(1, PBC_IDX_CTRL, 8'h10);
    wb(0, PBC_IDX_CTRL, 8'h2F);
    wb(1, PBC_IDX_CTRL, 8'h00);
    wb(1, PBC_IDX_CTRL, 8'h10);
    wb(0, PBC_IDX_CTRL, 8'h0F);
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      v = (i == 0) ? 8'h0A : rnd[7:0];
      wb(1, PBC_IDX_MR, v);
      wb(0, PBC_IDX_MR, v);
      `CHK(div, ((v[7:4] == 4'h0) ? 4'h1 : v[7:4]))
      `CHK(rng, v[3:0])
      `CHK(ctr, 20'(PBC_NOM_FREQ_100HZ * v[3:0]))
    end
    wb(1, PBC_IDX_MR, 8'h80);
    wb(1, PBC_IDX_CTRL, 8'h20);
    wb(1, PBC_IDX_CTRL, 8'h30);
    wait_cyc(8);
    `CHK(pll_out, 1'b0)
    `CHK(vact, 1'b0)
    wb(0, PBC_IDX_CTRL, 8'h2F);
    wb(1, PBC_IDX_CTRL, 8'h00);
    wb(1, PBC_IDX_MR, 8'h88);
    wb(1, PBC_IDX_CTRL, 8'h20);
    wait_cyc(30);
    wb(1, PBC_IDX_CTRL, 8'h30);
    wait_cyc(25);
    `CHK(vact, 1'b1)
    measure(1'b1);
    wb(1, PBC_IDX_CTRL, 8'h10);
    wb(0, PBC_IDX_CTRL, 8'h3F);
    stop <= 1'b1;
    wait_cyc(1);
    stop <= 1'b0;
    wb(0, PBC_IDX_CTRL, 8'h2F);
    wait_cyc(25);
    `CHK(vact, 1'b0)
    measure(1'b0);
    wb(1, PBC_IDX_BW, 8'h80);
    wb(1, PBC_IDX_CTRL, 8'hA0);
    wb(0, PBC_IDX_BW, 8'hC0);
    unlock <= 1'b1;
    wait_cyc(6);
    `CHK(irq, 1'b1)
    wb(0, PBC_IDX_CTRL, 8'hEF);
    wait_cyc(2);
    `CHK(irq, 1'b0)
    wb(0, PBC_IDX_CTRL, 8'hAF);
    wb(1, PBC_IDX_CTRL, 8'h20);
    unlock <= 1'b0;
    wait_cyc(6);
    `CHK(irq, 1'b0)
    wb(0, PBC_IDX_CTRL, 8'h6F);
    osc_en <= 1'b0;
    wait_cyc(4);
    `CHK(osc_out, 1'b0)
    `CHK(pll_out, 1'b0)
    osc_en <= 1'b1;
    wait_cyc(4);
    `CHK(osc_out, 1'b1)
    summarize();
  end
endmodule
